// file: include/wdst_pkg.sv
// package for the watchdog and pll settling timer
// assumes one system clock at 20 MHz and a classic wishbone master
package wdst_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] WDST_OFS_COUNTER = 8'h00;
  localparam logic [7:0] WDST_OFS_CTRL_STATUS = 8'h04;
  localparam logic [7:0] WDST_OFS_FREQ = 8'h08;
  localparam logic [7:0] WDST_OFS_STATUS = 8'h0c;

  // ==========================================================
  // write keys and field positions
  localparam logic [7:0] WDST_KEY_COUNTER = 8'h5a;
  localparam logic [7:0] WDST_KEY_CTRL = 8'ha5;
  localparam logic [3:0] WDST_SEL_WORD16 = 4'h3;
  localparam int WDST_POS_MULT = 8;
  localparam int WDST_POS_CORE_DIV = 4;
  localparam int WDST_POS_PERIPH_DIV = 0;

  // ==========================================================
  // values after power-on reset
  localparam logic [7:0] WDST_RST_COUNTER = 8'h00;
  localparam logic [7:0] WDST_RST_CTRL = 8'h00;
  localparam logic [1:0] WDST_RST_MULT = 2'h0;
  localparam logic [1:0] WDST_RST_CORE_DIV = 2'h0;
  localparam logic [1:0] WDST_RST_PERIPH_DIV = 2'h3;
  localparam logic [7:0] WDST_COUNT_MAX = 8'hff;

  // ==========================================================
  // prescaler masks for the eight count clock divisions
  localparam int WDST_PRE_BITS = 12;
  localparam logic [7:0][11:0] WDST_PRE_MASK = {
    12'hfff, 12'h3ff, 12'h0ff, 12'h03f, 12'h01f, 12'h00f, 12'h003, 12'h000
  };

  // ==========================================================
  // carriers
  typedef struct packed {
    logic run;
    logic mode;
    logic reset_kind_select;
    logic watchdog_overflow_flag;
    logic interval_overflow_flag;
    logic [2:0] cks;
  } wdst_csr_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wdst_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wdst_wb_rsp_type;

endpackage : wdst_pkg

// file: logic/wdst_prescaler.sv
// count clock prescaler for the watchdog counter
// assumes step is a one-cycle peripheral clock enable
`timescale 1ns/1ps

module wdst_prescaler
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic step,
  input wire logic [2:0] count_clock_select,
  output logic tick
);

  typedef struct packed {
    logic [11:0] pre;
  } wdst_pre_state_type;

  wdst_pre_state_type st_r;
  wdst_pre_state_type st_nxt;
  logic [11:0] mask;

  always_comb
  begin
    st_nxt = st_r;
    mask = wdst_pkg::WDST_PRE_MASK[count_clock_select];
    tick = step && ((st_r.pre & mask) == mask); // [RULE13]
    if (step)
    begin
      st_nxt.pre = st_r.pre + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : wdst_prescaler

// file: logic/wdst_timer.sv
// watchdog / interval timer that also times pll settling
// assumes reset is the power-on reset pin; internal resets are outputs only
`timescale 1ns/1ps

// What this block does
// RULE1: pll multiply ratio is one after reset
// RULE2: software stops timer, loads count before change
// RULE3: new multiply ratio pauses cpu, clocks counter
// RULE4: overflow ends settling, applies clocks, stops counter
// RULE5: division-only change starts no settling count
// RULE6: division-only change applies immediately
// RULE7: core divide 00, peripheral divide 11 after reset
// RULE8: software programs only legal division ratios
// RULE9: clock mode pins sampled at power-on reset only
// RULE10: single counter on peripheral clock, two modes
// RULE11: watchdog overflow raises power-on or manual reset
// RULE12: interval overflow raises interrupt, no reset
// RULE13: eight count clocks from one to 1/4096
// RULE14: eight-bit counter, counts on selected clock
// RULE15: counter kept over own reset, cleared by pin
// RULE16: counter written by 16-bit access, key 5a
// RULE17: control written by 16-bit access, key a5
// RULE18: mode bit selects; flags set in own mode
// RULE19: reset kind bit: 0 power-on, 1 manual
// RULE20: run enable low holds count, high resumes
// RULE21: overflow from ff, counter wraps to zero
// RULE22: wrong key writes are ignored
module wdst_timer
(
  input wire logic clk_sys,
  input wire logic reset,
  input wdst_pkg::wdst_wb_req_type wb_req,
  output wdst_pkg::wdst_wb_rsp_type wb_rsp,
  input wire logic [2:0] clock_mode_pins,
  output logic [2:0] clock_mode,
  output logic [1:0] pll_multiply_ratio,
  output logic [1:0] core_clock_divide,
  output logic [1:0] periph_clock_divide,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic cpu_pause,
  output logic bus_clock_pin,
  output logic por_request,
  output logic manual_request,
  output logic interval_irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] cnt;
    wdst_pkg::wdst_csr_type csr;
    logic [1:0] mult;
    logic [1:0] core_div;
    logic [1:0] periph_div;
    logic [1:0] applied_mult;
    logic [1:0] applied_core;
    logic [1:0] applied_periph;
    logic settle;
    logic [2:0] mode_pins;
    logic strap_taken;
    logic [1:0] core_phase;
    logic [1:0] periph_phase;
    logic bus_clk;
    logic por_req;
    logic man_req;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } wdst_state_type;

  wdst_state_type st_r;
  wdst_state_type st_nxt;

  logic req;
  logic wr;
  logic key16;
  logic wr_cnt_ok;
  logic wr_csr_ok;
  logic wr_freq;
  logic periph_pre;
  logic core_pre;
  logic count_tick;
  logic inc;
  logic ovf;
  logic [1:0] new_mult;
  logic [1:0] new_core;
  logic [1:0] new_periph;

  localparam int WDST_MULT_HI = wdst_pkg::WDST_POS_MULT + 1;
  localparam int WDST_CORE_HI = wdst_pkg::WDST_POS_CORE_DIV + 1;
  localparam int WDST_PER_HI = wdst_pkg::WDST_POS_PERIPH_DIV + 1;

  // ==========================================================
  // count clock prescaler
  wdst_prescaler i_wdst_prescaler
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .step(periph_pre),
    .count_clock_select(st_r.csr.cks),
    .tick(count_tick)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    req = wb_req.cyc && wb_req.stb && !st_r.ack;
    wr = req && wb_req.we;
    key16 = wb_req.sel == wdst_pkg::WDST_SEL_WORD16;
    wr_cnt_ok = wr && (wb_req.adr == wdst_pkg::WDST_OFS_COUNTER) && key16
      && (wb_req.dat[15:8] == wdst_pkg::WDST_KEY_COUNTER); // [RULE16] [RULE22]
    wr_csr_ok = wr && (wb_req.adr == wdst_pkg::WDST_OFS_CTRL_STATUS) && key16
      && (wb_req.dat[15:8] == wdst_pkg::WDST_KEY_CTRL); // [RULE17] [RULE22]
    wr_freq = wr && (wb_req.adr == wdst_pkg::WDST_OFS_FREQ) && (wb_req.sel[1:0] != 2'h0);
    new_mult = wb_req.sel[1] ? wb_req.dat[WDST_MULT_HI:wdst_pkg::WDST_POS_MULT] : st_r.mult;
    new_core = wb_req.sel[0] ? wb_req.dat[WDST_CORE_HI:wdst_pkg::WDST_POS_CORE_DIV] : st_r.core_div;
    new_periph = wb_req.sel[0] ? wb_req.dat[WDST_PER_HI:wdst_pkg::WDST_POS_PERIPH_DIV] : st_r.periph_div;

    // peripheral and core clock enables from the applied ratios
    periph_pre = st_r.periph_phase == st_r.applied_periph;
    core_pre = st_r.core_phase == st_r.applied_core;
    st_nxt.periph_phase = periph_pre ? 2'h0 : st_r.periph_phase + 2'h1;
    st_nxt.core_phase = core_pre ? 2'h0 : st_r.core_phase + 2'h1;
    st_nxt.bus_clk = !st_r.bus_clk; // [RULE3]

    // clock mode straps caught once after power-on reset release
    if (!st_r.strap_taken)
    begin
      st_nxt.mode_pins = clock_mode_pins; // [RULE9]
      st_nxt.strap_taken = 1'b1;
    end

    // counter
    inc = count_tick && (st_r.csr.run || st_r.settle); // [RULE3] [RULE10] [RULE14] [RULE20]
    ovf = inc && (st_r.cnt == wdst_pkg::WDST_COUNT_MAX); // [RULE21]
    st_nxt.por_req = 1'b0;
    st_nxt.man_req = 1'b0;
    st_nxt.irq = 1'b0;
    if (wr_cnt_ok)
    begin
      st_nxt.cnt = wb_req.dat[7:0];
    end
    else if (inc)
    begin
      st_nxt.cnt = st_r.cnt + 8'h01; // [RULE21]
    end

    // control/status write; flags clear on 0, an overflow this cycle wins
    if (wr_csr_ok)
    begin
      st_nxt.csr = wb_req.dat[7:0];
      st_nxt.csr.watchdog_overflow_flag = st_r.csr.watchdog_overflow_flag && wb_req.dat[4];
      st_nxt.csr.interval_overflow_flag = st_r.csr.interval_overflow_flag && wb_req.dat[3];
    end

    if (ovf && !wr_cnt_ok)
    begin
      if (st_r.settle)
      begin
        st_nxt.settle = 1'b0; // [RULE4]
        st_nxt.applied_mult = st_r.mult;
        st_nxt.applied_core = st_r.core_div;
        st_nxt.applied_periph = st_r.periph_div;
        st_nxt.core_phase = 2'h0;
        st_nxt.periph_phase = 2'h0;
      end
      else if (st_r.csr.mode)
      begin
        st_nxt.csr.watchdog_overflow_flag = 1'b1; // [RULE18]
        st_nxt.por_req = !st_r.csr.reset_kind_select; // [RULE11] [RULE19]
        st_nxt.man_req = st_r.csr.reset_kind_select;
      end
      else
      begin
        st_nxt.csr.interval_overflow_flag = 1'b1; // [RULE18]
        st_nxt.irq = 1'b1; // [RULE12]
      end
    end

    // frequency control write
    if (wr_freq && !st_r.settle)
    begin
      st_nxt.mult = new_mult;
      st_nxt.core_div = new_core;
      st_nxt.periph_div = new_periph;
      if (new_mult != st_r.mult)
      begin
        st_nxt.settle = 1'b1; // [RULE3]
      end
      else
      begin
        st_nxt.applied_core = new_core; // [RULE5] [RULE6]
        st_nxt.applied_periph = new_periph;
        st_nxt.core_phase = 2'h0;
        st_nxt.periph_phase = 2'h0;
      end
    end

    // bus answer, one cycle after the request, dropped the next cycle
    st_nxt.ack = req;
    st_nxt.rdata = 32'h0000_0000;
    if (req && !wb_req.we)
    begin
      unique case (wb_req.adr)
        wdst_pkg::WDST_OFS_COUNTER: st_nxt.rdata = {24'h00_0000, st_r.cnt};
        wdst_pkg::WDST_OFS_CTRL_STATUS: st_nxt.rdata = {24'h00_0000, st_r.csr};
        wdst_pkg::WDST_OFS_FREQ: st_nxt.rdata = {22'h00_0000, st_r.mult, 2'h0, st_r.core_div,
          2'h0, st_r.periph_div};
        wdst_pkg::WDST_OFS_STATUS: st_nxt.rdata = {20'h0_0000, st_r.mode_pins, st_r.settle,
          2'h0, st_r.applied_mult, 2'h0, st_r.applied_core};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // registers; cleared only by the power-on reset pin
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.cnt <= wdst_pkg::WDST_RST_COUNTER; // [RULE15]
      st_r.csr <= wdst_pkg::WDST_RST_CTRL;
      st_r.mult <= wdst_pkg::WDST_RST_MULT; // [RULE1]
      st_r.applied_mult <= wdst_pkg::WDST_RST_MULT;
      st_r.core_div <= wdst_pkg::WDST_RST_CORE_DIV; // [RULE7]
      st_r.applied_core <= wdst_pkg::WDST_RST_CORE_DIV;
      st_r.periph_div <= wdst_pkg::WDST_RST_PERIPH_DIV;
      st_r.applied_periph <= wdst_pkg::WDST_RST_PERIPH_DIV;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign wb_rsp.ack = st_r.ack;
  assign wb_rsp.dat = st_r.rdata;
  assign clock_mode = st_r.mode_pins;
  assign pll_multiply_ratio = st_r.applied_mult;
  assign core_clock_divide = st_r.applied_core;
  assign periph_clock_divide = st_r.applied_periph;
  assign core_clk_en = core_pre && !st_r.settle; // [RULE3]
  assign periph_clk_en = periph_pre && !st_r.settle;
  assign cpu_pause = st_r.settle;
  assign bus_clock_pin = st_r.bus_clk;
  assign por_request = st_r.por_req;
  assign manual_request = st_r.man_req;
  assign interval_irq = st_r.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  settle_start_a: assert property (wr_freq && !st_r.settle && (new_mult != st_r.mult) // [RULE3]
    |=> cpu_pause && !core_clk_en && !periph_clk_en && (pll_multiply_ratio == $past(st_r.applied_mult)))
    else $error("settling did not start on multiply change");

  settle_end_a: assert property (st_r.settle && ovf && !wr_cnt_ok // [RULE4]
    |=> !cpu_pause && (pll_multiply_ratio == st_r.mult) && !inc [*2])
    else $error("settling did not end cleanly on overflow");

  div_only_a: assert property (wr_freq && !st_r.settle && (new_mult == st_r.mult) // [RULE5]
    |=> !cpu_pause && (core_clock_divide == $past(new_core)) && (periph_clock_divide == $past(new_periph)))
    else $error("division change not applied at once");

  cnt_wrap_a: assert property (ovf && !wr_cnt_ok |=> st_r.cnt == 8'h00) // [RULE21]
    else $error("counter did not wrap to zero");

  cnt_hold_a: assert property (!st_r.csr.run && !st_r.settle && !wr_cnt_ok |=> $stable(st_r.cnt)) // [RULE20]
    else $error("stopped counter changed");

  bad_key_a: assert property (wr && (wb_req.adr == wdst_pkg::WDST_OFS_COUNTER) && !wr_cnt_ok // [RULE22]
    && !inc |=> $stable(st_r.cnt))
    else $error("counter changed on a keyless write");

  wd_reset_a: assert property (ovf && !wr_cnt_ok && !st_r.settle && st_r.csr.mode // [RULE11]
    |=> (por_request != manual_request) && (manual_request == $past(st_r.csr.reset_kind_select)) && !interval_irq
    ##1 !por_request && !manual_request)
    else $error("watchdog overflow reset wrong");

  itv_irq_a: assert property (ovf && !wr_cnt_ok && !st_r.settle && !st_r.csr.mode // [RULE12]
    |=> interval_irq && st_r.csr.interval_overflow_flag && !por_request && !manual_request)
    else $error("interval overflow did not interrupt");

  strap_hold_a: assert property (st_r.strap_taken |=> $stable(clock_mode)) // [RULE9]
    else $error("clock mode changed after reset");

  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held over two cycles");

endmodule : wdst_timer

// file: bench/wdst_timer_tb.sv
// self-checking bench for the watchdog and pll settling timer
// assumes a one-cycle wishbone ack and the register map of wdst_pkg
`timescale 1ns/1ps

module wdst_timer_tb;

  // ==========================================================
  // stimulus and observed signals
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  wdst_pkg::wdst_wb_req_type wb_req = '0;
  wdst_pkg::wdst_wb_rsp_type wb_rsp;
  logic [2:0] clock_mode_pins = 3'h5;
  logic [2:0] clock_mode;
  logic [1:0] pll_multiply_ratio;
  logic [1:0] core_clock_divide;
  logic [1:0] periph_clock_divide;
  logic core_clk_en, periph_clk_en, cpu_pause, bus_clock_pin;
  logic por_request, manual_request, interval_irq;
  logic pause_q = 1'b0;
  logic b;
  logic [31:0] rd, a;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int por_n = 0, man_n = 0, rst_n = 0, irq_n = 0, unpause_n = 0;

  wdst_timer i_wdst_timer
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .clock_mode_pins(clock_mode_pins),
    .clock_mode(clock_mode),
    .pll_multiply_ratio(pll_multiply_ratio),
    .core_clock_divide(core_clock_divide),
    .periph_clock_divide(periph_clock_divide),
    .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en),
    .cpu_pause(cpu_pause),
    .bus_clock_pin(bus_clock_pin),
    .por_request(por_request),
    .manual_request(manual_request),
    .interval_irq(interval_irq)
  );

  always #25 clk_sys = ~clk_sys;

  // ==========================================================
  // event counters and hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    por_n += por_request;
    man_n += manual_request;
    rst_n += por_request + manual_request;
    irq_n += interval_irq;
    if (pause_q === 1'b1 && cpu_pause === 1'b0)
      unpause_n++;
    pause_q <= cpu_pause;
    if (cycles == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // tasks
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic cycle; held until ack is sampled high
  task wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do
      @(posedge clk_sys);
    while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb

  task wr_key(input logic [7:0] adr, input logic [7:0] key, input logic [7:0] v);
    wb(1'b1, adr, wdst_pkg::WDST_SEL_WORD16, {16'h0000, key, v});
  endtask : wr_key

  task rd_reg(input logic [7:0] adr);
    wb(1'b0, adr, 4'h1, 32'h0000_0000);
  endtask : rd_reg

  task automatic wait_cnt(ref int c, input int goal);
    while (c < goal)
      @(posedge clk_sys);
  endtask : wait_cnt

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    clock_mode_pins <= 3'h2;
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    check("counter", rd, 32'h0);
    rd_reg(wdst_pkg::WDST_OFS_CTRL_STATUS);
    check("control", rd, 32'h0);
    rd_reg(wdst_pkg::WDST_OFS_FREQ);
    check("freq", rd, 32'h3);
    rd_reg(wdst_pkg::WDST_OFS_STATUS);
    check("status mode", rd[11:9], 3'h5);
    check("mult", pll_multiply_ratio, 2'h0);
    check("cdiv", core_clock_divide, 2'h0);
    check("pdiv", periph_clock_divide, 2'h3);
    $display("test reset done");

    wr_key(wdst_pkg::WDST_OFS_COUNTER, wdst_pkg::WDST_KEY_COUNTER, 8'h33);
    wr_key(wdst_pkg::WDST_OFS_COUNTER, wdst_pkg::WDST_KEY_CTRL, 8'h44);
    wb(1'b1, wdst_pkg::WDST_OFS_COUNTER, 4'h1, {16'h0000, wdst_pkg::WDST_KEY_COUNTER, 8'h55});
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    check("counter key", rd, 32'h33);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_COUNTER, 8'h07);
    rd_reg(wdst_pkg::WDST_OFS_CTRL_STATUS);
    check("control bad key", rd, 32'h0);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h07);
    rd_reg(wdst_pkg::WDST_OFS_CTRL_STATUS);
    check("control key", rd, 32'h07);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h00);
    rd_reg(8'h10);
    check("unmapped", rd, 32'h0);
    $display("test keys done");

    // interval mode, run, undivided count clock
    wr_key(wdst_pkg::WDST_OFS_COUNTER, wdst_pkg::WDST_KEY_COUNTER, 8'hfe);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h80);
    wait_cnt(irq_n, 1);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h08);
    rd_reg(wdst_pkg::WDST_OFS_CTRL_STATUS);
    check("interval flags", rd, 32'h08);
    check("no reset", rst_n, 0);
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    check("wrap", rd[7:0] < 8'h10, 1'b1);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h00);
    $display("test interval done");

    for (int k = 0; k < 2; k++)
    begin
      wr_key(wdst_pkg::WDST_OFS_COUNTER, wdst_pkg::WDST_KEY_COUNTER, 8'hfe);
      wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, {2'b11, k[0], 5'h00});
      wait_cnt(rst_n, k + 1);
      wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, {2'b01, k[0], 5'h10});
      rd_reg(wdst_pkg::WDST_OFS_CTRL_STATUS);
      check("watchdog flags", rd, {24'h0, 2'b01, k[0], 5'h10});
      check("por count", por_n, 1);
      check("manual count", man_n, k);
      check("irq count", irq_n, 1);
      wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h00);
    end
    $display("test watchdog done");

    wr_key(wdst_pkg::WDST_OFS_COUNTER, wdst_pkg::WDST_KEY_COUNTER, 8'h10);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h80);
    repeat (40) @(posedge clk_sys);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h00);
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    a = rd;
    check("counted up", a[7:0] > 8'h10, 1'b1);
    repeat (40) @(posedge clk_sys);
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    check("held", rd, a);
    $display("test run enable done");

    // count clock /4 of the peripheral enable: 4 or 5 steps in 67 cycles
    wr_key(wdst_pkg::WDST_OFS_COUNTER, wdst_pkg::WDST_KEY_COUNTER, 8'h00);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h81);
    repeat (64) @(posedge clk_sys);
    wr_key(wdst_pkg::WDST_OFS_CTRL_STATUS, wdst_pkg::WDST_KEY_CTRL, 8'h00);
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    check("count by 4", (rd[7:0] >= 8'h03) && (rd[7:0] <= 8'h05), 1'b1);
    $display("test count clock done");

    // multiply change: x2, both dividers /2
    wr_key(wdst_pkg::WDST_OFS_COUNTER, wdst_pkg::WDST_KEY_COUNTER, 8'hf0);
    wb(1'b1, wdst_pkg::WDST_OFS_FREQ, wdst_pkg::WDST_SEL_WORD16, 32'h0000_0115);
    check("pause", cpu_pause, 1'b1);
    check("mult held", pll_multiply_ratio, 2'h0);
    b = bus_clock_pin;
    @(posedge clk_sys);
    check("bus clock", bus_clock_pin, !b);
    check("core stopped", core_clk_en, 1'b0);
    check("periph stopped", periph_clk_en, 1'b0);
    wait_cnt(unpause_n, 1);
    check("mult new", pll_multiply_ratio, 2'h1);
    check("cdiv new", core_clock_divide, 2'h1);
    check("pdiv new", periph_clock_divide, 2'h1);
    check("settle no event", rst_n + irq_n, 3);
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    a = rd;
    repeat (20) @(posedge clk_sys);
    rd_reg(wdst_pkg::WDST_OFS_COUNTER);
    check("counter stopped", rd, a);
    $display("test settling done");

    wb(1'b1, wdst_pkg::WDST_OFS_FREQ, wdst_pkg::WDST_SEL_WORD16, 32'h0000_0123);
    check("no pause", cpu_pause, 1'b0);
    check("cdiv now", core_clock_divide, 2'h2);
    check("pdiv now", periph_clock_divide, 2'h3);
    repeat (10) @(posedge clk_sys);
    check("no settle", unpause_n, 1);
    check("mode kept", clock_mode, 3'h5);
    $display("test division done");
    give_verdict();
  end

endmodule : wdst_timer_tb
